// *** smc_supply_mode_controller.sv ***
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_supply_mode_controller #(
  parameter int PorCyc    = `SMC_POR_US * `SMC_CLK_MHZ,
  parameter int PgmCyc    = `SMC_PGM_SETTLE_US * `SMC_CLK_MHZ,
  parameter int WakeCyc   = `SMC_WAKE_US * `SMC_CLK_MHZ,
  parameter int IdleCyc   = `SMC_IDLE_US * `SMC_CLK_MHZ,
  parameter int DebCyc    = `SMC_DEB_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Supply comparators and programming window
  input  wire logic        supplyBelowPowerdown,
  input  wire logic        supplyAbovePowerup,
  input  wire logic        supplyAboveExtMin,
  input  wire logic        supplyAboveNomMin,
  input  wire logic        programWindowIn,
  // Bus receiver and frame decoder events
  input  wire logic        busRx,
  input  wire logic        foreignFlashSeen,
  input  wire logic        sleepCmd,
  input  wire logic        diagRequestValid,
  // Mode outputs
  output logic [2:0]       outStageEnable,
  output logic             xcvrEnable,
  output logic             flashMode,
  output logic             termEnable,
  output logic             rxEnable,
  output logic             wakeCompEnable,
  output logic             cmdEnable,
  output logic             resetErrFlag,
  output logic [2:0]       modeOut,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ****************************************
  // Input conditioning
  // ****************************************
  localparam int NumLvl = 5;
  logic [NumLvl-1:0] lvlRaw;
  logic [NumLvl-1:0] lvlQ;
  assign lvlRaw = {programWindowIn, supplyAboveNomMin, supplyAboveExtMin, supplyAbovePowerup, supplyBelowPowerdown};

  // Two-flop sync then a stability count per level, so comparator chatter cannot flip modes
  genvar gi;
  generate
    for (gi = 0; gi < NumLvl; gi++) begin : g_lvl
      logic        s1Q, s2Q;
      logic [15:0] debQ;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          s1Q     <= 1'b0;
          s2Q     <= 1'b0;
          debQ    <= 16'h0000;
          lvlQ[gi] <= 1'b0;
        end else begin
          s1Q <= lvlRaw[gi];
          s2Q <= s1Q;
          if (s2Q == lvlQ[gi]) begin
            debQ <= 16'h0000;
          end else if (debQ == 16'(DebCyc - 1)) begin
            debQ     <= 16'h0000;
            lvlQ[gi] <= s2Q;
          end else begin
            debQ <= debQ + 16'h0001;
          end
        end
      end
    end
  endgenerate

  logic lvlBelowPd, lvlAbovePu, lvlAboveExt, lvlPgm;
  assign lvlBelowPd  = lvlQ[0];
  assign lvlAbovePu  = lvlQ[1];
  assign lvlAboveExt = lvlQ[2];
  assign lvlPgm      = lvlQ[4];

  // ****************************************
  // Timers
  // ****************************************
  smc_pkg::smc_mode_t mode_q, mode_d;
  logic [31:0] porCnt_q, pgmCnt_q, idleCnt_q, domCnt_q;
  logic        busRxPrev_q, wakeArmed_q;
  logic        porDone, pgmDone, idleDone, wakeRise;

  assign porDone  = (porCnt_q == 32'(PorCyc - 1));
  assign pgmDone  = (pgmCnt_q >= 32'(PgmCyc));
  assign idleDone = (idleCnt_q >= 32'(IdleCyc));
  assign wakeRise = wakeArmed_q && busRx && !busRxPrev_q;

  // Power-on reset delay runs only in start-up; it restarts once done so it never passes its bound
  always_ff @(posedge clk) begin
    if (!rst_n || mode_q != smc_pkg::ModeStartup || porDone) porCnt_q <= 32'h0000_0000;
    else porCnt_q <= porCnt_q + 32'h0000_0001;
  end

  // Window dwell, saturating; any exit from the window restarts it
  always_ff @(posedge clk) begin
    if (!rst_n || !lvlPgm || mode_q == smc_pkg::ModeReset) pgmCnt_q <= 32'h0000_0000;
    else if (!pgmDone) pgmCnt_q <= pgmCnt_q + 32'h0000_0001;
  end

  // Recessive time between messages; a dominant bit restarts it
  always_ff @(posedge clk) begin
    if (!rst_n || !busRx || !(mode_q == smc_pkg::ModeNormal || mode_q == smc_pkg::ModeStop)) begin
      idleCnt_q <= 32'h0000_0000;
    end else if (!idleDone) begin
      idleCnt_q <= idleCnt_q + 32'h0000_0001;
    end
  end

  // Wake filter: long dominant arms, the following rising edge fires
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busRxPrev_q <= 1'b1;
      domCnt_q    <= 32'h0000_0000;
      wakeArmed_q <= 1'b0;
    end else begin
      busRxPrev_q <= busRx;
      if (mode_q != smc_pkg::ModeSleep || (busRx && !wakeArmed_q)) begin
        domCnt_q    <= 32'h0000_0000;
        wakeArmed_q <= 1'b0;
      end else if (!busRx) begin
        if (domCnt_q >= 32'(WakeCyc)) wakeArmed_q <= 1'b1;
        else domCnt_q <= domCnt_q + 32'h0000_0001;
      end
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  // Reset condition is checked first so no other mode can survive a brown-out
  always_comb begin
    mode_d = mode_q;
    if (lvlBelowPd) begin
      mode_d = smc_pkg::ModeReset;
    end else begin
      unique case (mode_q)
        smc_pkg::ModeReset:   if (lvlAbovePu) mode_d = smc_pkg::ModeStartup;
        smc_pkg::ModeStartup: if (porDone) mode_d = smc_pkg::ModeNormal;
        smc_pkg::ModeNormal: begin
          if (pgmDone) mode_d = smc_pkg::ModeProgram;
          else if (foreignFlashSeen) mode_d = smc_pkg::ModeStop;
          else if (sleepCmd && lvlAboveExt) mode_d = smc_pkg::ModeSleep;
          else if (idleDone) mode_d = smc_pkg::ModeSleep;
        end
        smc_pkg::ModeProgram: begin
          if (!lvlPgm) mode_d = smc_pkg::ModeNormal;
          else if (foreignFlashSeen) mode_d = smc_pkg::ModeStop;
        end
        smc_pkg::ModeStop: begin
          if (pgmDone) mode_d = smc_pkg::ModeProgram;
          else if (idleDone) mode_d = smc_pkg::ModeSleep;
        end
        smc_pkg::ModeSleep:   if (wakeRise) mode_d = smc_pkg::ModeStartup;
        default:              mode_d = smc_pkg::ModeReset;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) mode_q <= smc_pkg::ModeReset;
    else mode_q <= mode_d;
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [2:0] chEn_q;
  logic       awHeld_q, wHeld_q;
  logic [3:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic       doWrite;
  assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

  // Address and data are latched independently, so either may come first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (doWrite) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Channel-enable control register; a supply power-on reset restores it like the pin reset does
  always_ff @(posedge clk) begin
    if (!rst_n || mode_q == smc_pkg::ModeReset) begin
      chEn_q <= `SMC_CTRL_RST;
    end else if (doWrite && awAddr_q == `SMC_ADDR_CTRL && wStrb_q[0]) begin
      chEn_q <= wData_q[`SMC_CTRL_CH_LSB +: `SMC_CTRL_CH_W];
    end
  end

  // Write response; anything but the two mapped words answers DECERR
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SMC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_q == `SMC_ADDR_CTRL || awAddr_q == `SMC_ADDR_STATUS) ? `SMC_RESP_OKAY : `SMC_RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !doWrite;
      s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !doWrite;
    end
  end

  // Read path answers one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `SMC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      if (s_axi_araddr == `SMC_ADDR_CTRL) begin
        s_axi_rdata[`SMC_CTRL_CH_LSB +: `SMC_CTRL_CH_W] <= chEn_q;
      end else if (s_axi_araddr == `SMC_ADDR_STATUS) begin
        s_axi_rdata[`SMC_ST_MODE_LSB +: 3] <= mode_q;
        s_axi_rdata[`SMC_ST_RSTERR]        <= resetErrFlag;
        s_axi_rdata[`SMC_ST_LVL_LSB +: 5]  <= lvlQ;
        s_axi_rdata[`SMC_ST_XCVR]          <= xcvrEnable;
      end else begin
        s_axi_rresp <= `SMC_RESP_DECERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Decoded from the next mode so every pin is a flop yet tracks the mode in the same cycle
  logic stagesOn, commsMode;
  assign stagesOn  = (mode_d == smc_pkg::ModeNormal || mode_d == smc_pkg::ModeStop);
  assign commsMode = (mode_d == smc_pkg::ModeNormal || mode_d == smc_pkg::ModeProgram);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outStageEnable <= 3'h0;
      xcvrEnable     <= 1'b0;
      flashMode      <= 1'b0;
      termEnable     <= 1'b0;
      rxEnable       <= 1'b0;
      wakeCompEnable <= 1'b0;
      cmdEnable      <= 1'b0;
      modeOut        <= 3'h0;
    end else begin
      outStageEnable <= stagesOn ? chEn_q : 3'h0;
      xcvrEnable     <= commsMode && lvlAboveExt;
      flashMode      <= (mode_d == smc_pkg::ModeProgram);
      termEnable     <= (mode_d != smc_pkg::ModeSleep && mode_d != smc_pkg::ModeReset);
      rxEnable       <= (mode_d != smc_pkg::ModeSleep && mode_d != smc_pkg::ModeReset);
      wakeCompEnable <= (mode_d == smc_pkg::ModeSleep);
      cmdEnable      <= (mode_d == smc_pkg::ModeNormal) && lvlAboveExt;
      modeOut        <= mode_d;
    end
  end

  // Sticky reset error; leaving reset sets it and wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) resetErrFlag <= 1'b0;
    else if (mode_q == smc_pkg::ModeReset && mode_d == smc_pkg::ModeStartup) resetErrFlag <= 1'b1;
    else if (diagRequestValid && cmdEnable) resetErrFlag <= 1'b0;
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wakeFire;
    mode_q == smc_pkg::ModeSleep && wakeRise && !lvlBelowPd;
  endsequence

  a_brownout_reset: assert property (lvlBelowPd |=> mode_q == smc_pkg::ModeReset ##1 outStageEnable == 3'h0)
    else $error("reset condition not entered");
  a_startup_normal: assert property (mode_q == smc_pkg::ModeStartup && porDone && !lvlBelowPd
    |=> mode_q == smc_pkg::ModeNormal)
    else $error("start-up did not reach normal");
  a_por_bound: assert property (porCnt_q < 32'(PorCyc))
    else $error("power-on delay overran");
  a_prog_outputs: assert property (mode_q == smc_pkg::ModeProgram |-> outStageEnable == 3'h0 && flashMode)
    else $error("programming mode outputs wrong");
  a_prog_entry: assert property ($rose(mode_q == smc_pkg::ModeProgram) |-> $past(pgmDone))
    else $error("programming entered before settle time");
  a_sleep_pins: assert property (mode_q == smc_pkg::ModeSleep |-> !termEnable && !rxEnable && wakeCompEnable)
    else $error("sleep pins wrong");
  a_wake_steps: assert property (s_wakeFire |=> mode_q == smc_pkg::ModeStartup ##1 !wakeCompEnable)
    else $error("wake did not start power-on reset");
  a_stop_lock: assert property (mode_q == smc_pkg::ModeNormal && foreignFlashSeen && !pgmDone && !lvlBelowPd
    |=> mode_q == smc_pkg::ModeStop ##1 !xcvrEnable)
    else $error("stop lock missed");
  a_rsterr_set: assert property (mode_q == smc_pkg::ModeReset && mode_d == smc_pkg::ModeStartup |=> resetErrFlag)
    else $error("reset error not set");
  a_lowv_xcvr: assert property (!lvlAboveExt && !lvlBelowPd |=> !xcvrEnable)
    else $error("transceiver active below extended minimum");

endmodule : smc_supply_mode_controller

// *** smc_consts.svh ***
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// Timing, in printed units, and clock rate
`define SMC_CLK_MHZ        250
`define SMC_POR_US         5000
`define SMC_PGM_SETTLE_US  1000
`define SMC_WAKE_US        100
`define SMC_IDLE_US        4000000
`define SMC_DEB_CYC        8
// Register map, byte addresses
`define SMC_ADDR_CTRL      4'h0
`define SMC_ADDR_STATUS    4'h4
// Field positions
`define SMC_CTRL_CH_LSB    0
`define SMC_CTRL_CH_W      3
`define SMC_ST_MODE_LSB    0
`define SMC_ST_RSTERR      3
`define SMC_ST_LVL_LSB     4
`define SMC_ST_XCVR        9
// Reset values and answers
`define SMC_CTRL_RST       3'h7
`define SMC_RESP_OKAY      2'h0
`define SMC_RESP_DECERR    2'h3
`endif

// *** smc_pkg.sv ***
package smc_pkg;
  // Operating modes, Gray coded along reset, start-up, normal, programming, stop, sleep
  typedef enum logic [2:0] {
    ModeReset   = 3'h0,
    ModeStartup = 3'h1,
    ModeNormal  = 3'h3,
    ModeProgram = 3'h2,
    ModeStop    = 3'h6,
    ModeSleep   = 3'h7
  } smc_mode_t;
endpackage : smc_pkg

// *** smc_bus_master.sv ***
`timescale 1ns/1ps
// ************************************
// Serial bus master model
// ************************************
module smc_bus_master (
  // Clock and frame pacing
  input  wire logic clk,
  input  wire logic traffic,
  // Bus level and decoded events
  output logic      busRx,
  output logic      sleepCmd,
  output logic      diagRequestValid,
  output logic      foreignFlashSeen
);
  int   gap = 0;
  logic holdDom = 1'b0;
  // Frame pacing; three low cycles stay under the wake time, so frames never wake a sleeper
  always @(posedge clk) gap <= (gap == 23) ? 0 : gap + 1;
  // Pull-up makes the released bus recessive
  assign busRx = !(holdDom || (traffic && gap < 3));
  // Events rest low until a command is sent
  initial begin
    sleepCmd = 1'b0;
    diagRequestValid = 1'b0;
    foreignFlashSeen = 1'b0;
  end
  // Falling edge, n cycles dominant, then the rising edge that wakes the node when n is longer than the wake time
  task automatic dominant(input int n);
    @(posedge clk);
    holdDom <= 1'b1;
    repeat (n) @(posedge clk);
    holdDom <= 1'b0;
  endtask : dominant
  // One-cycle decoded event: 0 sleep, 1 diagnosis request, 2 foreign flash traffic
  task automatic pulse(input int k);
    @(posedge clk);
    sleepCmd <= (k == 0);
    diagRequestValid <= (k == 1);
    foreignFlashSeen <= (k == 2);
    @(posedge clk);
    sleepCmd <= 1'b0;
    diagRequestValid <= 1'b0;
    foreignFlashSeen <= 1'b0;
  endtask : pulse
endmodule : smc_bus_master

// *** tb.sv ***
`timescale 1ns/1ps
`include "smc_consts.svh"
module tb;
  logic        clk, rst_n, belowPd, abovePu, aboveExt, aboveNom, window, traffic;
  logic [2:0]  outEn, mode, ctrl;
  logic        xcvr, flash, term, rxEn, wakeEn, cmdEn, rstErr, busRx, sleepCmd, diagReq, foreign;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  seed;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  logic [31:0] mq[$];
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  // ************************************
  // Design, partner, clock
  // ************************************
  smc_supply_mode_controller #(.PorCyc(20), .PgmCyc(10), .WakeCyc(5), .IdleCyc(50), .DebCyc(2)) uut (
    .clk(clk), .rst_n(rst_n), .supplyBelowPowerdown(belowPd), .supplyAbovePowerup(abovePu),
    .supplyAboveExtMin(aboveExt), .supplyAboveNomMin(aboveNom), .programWindowIn(window),
    .busRx(busRx), .foreignFlashSeen(foreign), .sleepCmd(sleepCmd), .diagRequestValid(diagReq),
    .outStageEnable(outEn), .xcvrEnable(xcvr), .flashMode(flash), .termEnable(term), .rxEnable(rxEn),
    .wakeCompEnable(wakeEn), .cmdEnable(cmdEn), .resetErrFlag(rstErr), .modeOut(mode),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  smc_bus_master bm (.clk(clk), .traffic(traffic), .busRx(busRx), .sleepCmd(sleepCmd),
    .diagRequestValid(diagReq), .foreignFlashSeen(foreign));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ************************************
  // Checking and closing
  // ************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // Hang guard, well above the length of the whole sequence
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      end_of_test();
    end
  end
  // Bus answers are matched against the oldest note taken at request time
  always @(posedge clk) begin
    if (bvalid && bready) check({32'h0, bresp}, {32'h0, wq.pop_front()});
    if (rvalid && rready) check({rresp, rdata & mq.pop_front()}, rq.pop_front());
  end
  // ************************************
  // Stimulus helpers
  // ************************************
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // Comparator and window levels, ordered {belowPd, abovePu, aboveExt, aboveNom, window}
  task automatic supply(input logic [4:0] v);
    @(posedge clk);
    {belowPd, abovePu, aboveExt, aboveNom, window} <= v;
  endtask : supply
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done
  // Bounded wait for a mode; outputs are looked at mid-cycle where they are settled
  task automatic waitMode(input logic [2:0] m, input int n);
    int i;
    @(negedge clk);
    for (i = 0; i < n && mode !== m; i++) @(negedge clk);
    check(mode, m);
  endtask : waitMode
  // Address and data offered together; each released at its own handshake edge
  task automatic axWrite(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    wq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw || awready;
      w = w || wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    do @(posedge clk); while (!bvalid);
    bready <= !bvalid;
  endtask : axWrite
  task automatic axRead(input logic [3:0] a, input logic [31:0] m, input logic [33:0] e);
    mq.push_back(m);
    rq.push_back(e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= !arready;
    do @(posedge clk); while (!rvalid);
    rready <= !rvalid;
  endtask : axRead
  task automatic wakeUp();
    bm.dominant(10);
    waitMode(smc_pkg::ModeStartup, 8);
    waitMode(smc_pkg::ModeNormal, 40);
  endtask : wakeUp
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    {rst_n, belowPd, window, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
    {abovePu, aboveExt, aboveNom, traffic} = 4'hF;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    seed = 8'h0E;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    waitMode(smc_pkg::ModeStartup, 20);
    check(outEn, 3'h0);
    waitMode(smc_pkg::ModeNormal, 40);
    check(rstErr, 1'b1);
    check(cmdEn, 1'b1);
    axRead(`SMC_ADDR_CTRL, 32'h7, {`SMC_RESP_OKAY, 32'h7});
    axRead(`SMC_ADDR_STATUS, 32'h20F, {`SMC_RESP_OKAY, 32'h20B});
    axRead(4'h8, 32'hFFFFFFFF, {`SMC_RESP_DECERR, 32'h0});
    bm.pulse(1);
    settle(3);
    check(rstErr, 1'b0);
    done("reset");
    seed = lfsr(seed);
    ctrl = seed[2:0];
    axWrite(`SMC_ADDR_CTRL, {29'h0, ctrl}, 4'hF, `SMC_RESP_OKAY);
    axWrite(`SMC_ADDR_STATUS, 32'h0, 4'hF, `SMC_RESP_OKAY);
    axWrite(4'hC, 32'h0, 4'hF, `SMC_RESP_DECERR);
    axWrite(`SMC_ADDR_CTRL, 32'h0, 4'hE, `SMC_RESP_OKAY);
    axRead(`SMC_ADDR_CTRL, 32'h7, {`SMC_RESP_OKAY, 29'h0, ctrl});
    settle(1);
    check(outEn, ctrl);
    done("registers");
    supply(5'h0C);
    settle(10);
    check(xcvr, 1'b1);
    supply(5'h08);
    settle(10);
    check(xcvr, 1'b0);
    check(outEn, ctrl);
    bm.pulse(0);
    settle(5);
    check(mode, smc_pkg::ModeNormal);
    supply(5'h0E);
    settle(10);
    check(xcvr, 1'b1);
    check(rstErr, 1'b0);
    supply(5'h1E);
    supply(5'h0E);
    settle(10);
    check(mode, smc_pkg::ModeNormal);
    done("low voltage");
    supply(5'h0F);
    repeat (3) @(posedge clk);
    supply(5'h0E);
    settle(20);
    check(mode, smc_pkg::ModeNormal);
    supply(5'h0F);
    waitMode(smc_pkg::ModeProgram, 30);
    check(flash, 1'b1);
    check(outEn, 3'h0);
    bm.pulse(2);
    settle(5);
    check(mode, smc_pkg::ModeProgram);
    supply(5'h0E);
    waitMode(smc_pkg::ModeNormal, 20);
    check(flash, 1'b0);
    done("programming");
    @(posedge clk);
    traffic <= 1'b0;
    bm.pulse(0);
    waitMode(smc_pkg::ModeSleep, 10);
    check({outEn, term, rxEn, cmdEn, wakeEn}, 7'h01);
    bm.dominant(3);
    settle(10);
    check(mode, smc_pkg::ModeSleep);
    wakeUp();
    waitMode(smc_pkg::ModeSleep, 80);
    wakeUp();
    @(posedge clk);
    traffic <= 1'b1;
    done("sleep and wake");
    bm.pulse(2);
    waitMode(smc_pkg::ModeStop, 8);
    bm.pulse(0);
    settle(5);
    check(mode, smc_pkg::ModeStop);
    @(posedge clk);
    traffic <= 1'b0;
    waitMode(smc_pkg::ModeSleep, 80);
    done("stop");
    supply(5'h10);
    waitMode(smc_pkg::ModeReset, 15);
    check({outEn, xcvr, cmdEn}, 5'h00);
    supply(5'h0E);
    traffic <= 1'b1;
    waitMode(smc_pkg::ModeNormal, 60);
    check(rstErr, 1'b1);
    axRead(`SMC_ADDR_CTRL, 32'h7, {`SMC_RESP_OKAY, 32'h7});
    settle(2);
    done("power down");
    end_of_test();
  end
endmodule : tb
